// *** patu_regs.vh ***
`ifndef PATU_REGS_VH
`define PATU_REGS_VH

// Register byte offsets on the Wishbone bus
`define PATU_OFF_CTRL 8'h00
`define PATU_OFF_STATUS 8'h04
`define PATU_OFF_HOLD_REF 8'h08
`define PATU_OFF_ACT_REF 8'h0C
`define PATU_OFF_ACT_MAIN 8'h10
`define PATU_OFF_TIMER 8'h14

// Control register fields and reset value
`define PATU_CTRL_REF_EN 0
`define PATU_CTRL_ADAPT_EN 1
`define PATU_CTRL_RESET 2'h3

// Status register fields
`define PATU_ST_HI 0
`define PATU_ST_LO 1
`define PATU_ST_TIMING 2
`define PATU_ST_PENDING 3
`define PATU_ST_MODE_ERR 4
`define PATU_ST_GAP_ERR 5

// Serial word lengths
`define PATU_HR_BITS 6'h10
`define PATU_N_BITS 6'h18

// Main divider word field positions
`define PATU_N_MAIN_MSB 17
`define PATU_N_RATIO 18
`define PATU_N_TSEL_LSB 19
`define PATU_N_TSEL_MSB 21
`define PATU_N_LOCKWIN 22
`define PATU_N_MODE 23

// Timer select codes
`define PATU_TSEL_HI_ONLY 3'h0
`define PATU_TSEL_LO_ONLY 3'h1

// Reference accumulator step: the holding value is twice the ratio
`define PATU_REF_STEP 17'h00002
`define PATU_REF_MIN 16'h0004

// Lock window in reference oscillator cycles
`define PATU_LOCK_WIN_NARROW 7'h20
`define PATU_LOCK_WIN_WIDE 7'h40

// High to low current ratio codes
`define PATU_RATIO_NARROW 4'h4
`define PATU_RATIO_WIDE 4'h8

// Least idle time between serial words, in reference oscillator cycles
`define PATU_GAP_OSC_CYCLES 5'h14

// Reset values
`define PATU_HOLD_REF_RESET 16'h0000
`define PATU_MAIN_RESET 24'h000000

`endif

// *** patu_sync.v ***
`timescale 1ns/1ps
module patu_sync #(
	parameter W = 4
) (
	input wire clk_i,
	input wire rst_i,
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			reg meta;
			reg stable;
			always @(posedge clk_i) begin
				if (rst_i) begin
					meta <= 1'b0;
					stable <= 1'b0;
				end else begin
					meta <= d_i[g];
					stable <= meta;
				end
			end
			assign q_o[g] = stable;
		end
	endgenerate
endmodule // patu_sync

// *** patu_top.v ***
`timescale 1ns/1ps
`include "patu_regs.vh"
module patu_top (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_sel_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire ser_clk_i,
	input wire ser_data_i,
	input wire ser_enb_n_i,
	input wire mode_i,
	output reg detector_high_current_out_o,
	output reg detector_low_current_out_o,
	output reg ref_divided_compare_rate_o,
	output reg [15:0] active_ref_o,
	output reg [17:0] active_main_o,
	output reg lock_window_select_o,
	output reg [6:0] lock_window_osc_o,
	output reg current_ratio_select_o,
	output reg [3:0] current_ratio_o
);
	wire [3:0] sync_q;
	wire s_clk;
	wire s_data;
	wire s_enb_n;
	wire s_mode;
	reg sclk_d;
	reg enb_d;
	reg [23:0] shreg;
	reg [5:0] bitcnt;
	reg [4:0] gap_cnt;
	reg [15:0] ref_divider_holding_reg;
	reg [2:0] adapt_timer_select;
	reg [15:0] ref_acc;
	reg timing;
	reg [7:0] timer;
	reg pend_valid;
	reg [15:0] pend_ref;
	reg [23:0] pend_word;
	reg [1:0] ctrl;
	reg mode_err;
	reg gap_err;
	reg [31:0] next_dat;
	wire sclk_rise;
	wire enb_rise;
	wire enb_fall;
	wire word_hr;
	wire word_n;
	wire [2:0] new_sel;
	wire new_adapt;
	wire expire;
	wire take_new;
	wire [16:0] ref_sum;
	wire [15:0] ref_left;
	wire fr_hit;
	wire [7:0] new_interval;
	wire wb_req;
	wire wb_wr;
	wire [23:0] exp_word;
	wire [15:0] exp_ref;

	patu_sync #(
		.W(4)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({mode_i, ~ser_enb_n_i, ser_data_i, ser_clk_i}),
		.q_o(sync_q)
	);

	assign s_clk = sync_q[0];
	assign s_data = sync_q[1];
	// Enable is inverted around the synchroniser so its reset level reads as idle
	assign s_enb_n = ~sync_q[2];
	assign s_mode = sync_q[3];
	assign sclk_rise = s_clk & ~sclk_d;
	assign enb_rise = s_enb_n & ~enb_d;
	assign enb_fall = ~s_enb_n & enb_d;
	// Word length at the end of a frame tells the two registers apart
	assign word_hr = enb_rise & (bitcnt == `PATU_HR_BITS);
	assign word_n = enb_rise & (bitcnt == `PATU_N_BITS);

	// Serial shift-in; the word is latched when enable returns high
	always @(posedge clk_i) begin
		if (rst_i) begin
			sclk_d <= 1'b0;
			enb_d <= 1'b1;
			shreg <= 24'h000000;
			bitcnt <= 6'h00;
			// Starts saturated so the first frame after reset is not flagged
			gap_cnt <= `PATU_GAP_OSC_CYCLES;
		end else begin
			sclk_d <= s_clk;
			enb_d <= s_enb_n;
			if (!s_enb_n && sclk_rise) begin
				shreg <= {shreg[22:0], s_data};
				if (bitcnt != 6'h3F) begin
					bitcnt <= bitcnt + 6'h01;
				end
			end else if (s_enb_n && enb_d) begin
				bitcnt <= 6'h00;
			end
			if (enb_rise) begin
				gap_cnt <= 5'h00;
			end else if (s_enb_n && gap_cnt != `PATU_GAP_OSC_CYCLES) begin
				gap_cnt <= gap_cnt + 5'h01;
			end
		end
	end

	// Adapt is decided from the main loop word and the control register adapt enable bit
	assign new_sel = shreg[`PATU_N_TSEL_MSB:`PATU_N_TSEL_LSB];
	assign new_adapt = ctrl[`PATU_CTRL_ADAPT_EN] & (new_sel != `PATU_TSEL_HI_ONLY)
		& (new_sel != `PATU_TSEL_LO_ONLY);
	// Interval is two to the power of the select code, so 1 0 1 gives 32
	assign new_interval = 8'h01 << new_sel;
	// The last compare pulse of the interval switches the detectors and loads the second set
	assign expire = timing & fr_hit & (timer == 8'h01);
	assign take_new = word_n & timing;
	assign exp_word = take_new ? shreg : pend_word;
	assign exp_ref = take_new ? ref_divider_holding_reg : pend_ref;

	// Half-unit ratios: accumulate two per oscillator cycle against twice the ratio
	assign ref_sum = {1'b0, ref_acc} + `PATU_REF_STEP;
	assign fr_hit = ctrl[`PATU_CTRL_REF_EN] & (active_ref_o >= `PATU_REF_MIN)
		& (ref_sum >= {1'b0, active_ref_o});
	assign ref_left = ref_sum[15:0] - active_ref_o;

	always @(posedge clk_i) begin
		if (rst_i) begin
			ref_acc <= 16'h0000;
			ref_divided_compare_rate_o <= 1'b0;
		end else begin
			ref_divided_compare_rate_o <= fr_hit;
			if (!ctrl[`PATU_CTRL_REF_EN] || active_ref_o < `PATU_REF_MIN) begin
				ref_acc <= 16'h0000;
			end else if (fr_hit) begin
				// Only the half-unit remainder is carried, so a smaller new ratio gives no pulse burst
				ref_acc <= {15'h0000, ref_left[0]};
			end else begin
				ref_acc <= ref_sum[15:0];
			end
		end
	end

	// Tuning core: holding, active and deferred data sets
	always @(posedge clk_i) begin
		if (rst_i) begin
			ref_divider_holding_reg <= `PATU_HOLD_REF_RESET;
			active_ref_o <= `PATU_HOLD_REF_RESET;
			active_main_o <= 18'h00000;
			adapt_timer_select <= 3'h0;
			lock_window_select_o <= 1'b0;
			current_ratio_select_o <= 1'b0;
			detector_high_current_out_o <= 1'b1;
			detector_low_current_out_o <= 1'b0;
			timing <= 1'b0;
			timer <= 8'h00;
			pend_valid <= 1'b0;
			pend_ref <= `PATU_HOLD_REF_RESET;
			pend_word <= `PATU_MAIN_RESET;
		end else begin
			if (word_hr) begin
				ref_divider_holding_reg <= shreg[15:0];
			end
			if (expire) begin
				timing <= 1'b0;
				timer <= 8'h00;
				detector_high_current_out_o <= 1'b0;
				detector_low_current_out_o <= 1'b1;
				if (pend_valid || take_new) begin
					active_ref_o <= exp_ref;
					active_main_o <= exp_word[`PATU_N_MAIN_MSB:0];
					adapt_timer_select <= exp_word[`PATU_N_TSEL_MSB:`PATU_N_TSEL_LSB];
					lock_window_select_o <= exp_word[`PATU_N_LOCKWIN];
					current_ratio_select_o <= exp_word[`PATU_N_RATIO];
				end
				pend_valid <= 1'b0;
			end else if (take_new) begin
				pend_ref <= ref_divider_holding_reg;
				pend_word <= shreg;
				pend_valid <= 1'b1;
				// A compare pulse in the cycle the second word lands still counts
				if (fr_hit) begin
					timer <= timer - 8'h01;
				end
			end else if (word_n) begin
				active_ref_o <= ref_divider_holding_reg;
				active_main_o <= shreg[`PATU_N_MAIN_MSB:0];
				adapt_timer_select <= new_sel;
				lock_window_select_o <= shreg[`PATU_N_LOCKWIN];
				current_ratio_select_o <= shreg[`PATU_N_RATIO];
				if (new_adapt) begin
					timing <= 1'b1;
					timer <= new_interval;
					detector_high_current_out_o <= 1'b1;
					detector_low_current_out_o <= 1'b0;
				end else begin
					detector_high_current_out_o <= (new_sel == `PATU_TSEL_HI_ONLY);
					detector_low_current_out_o <= (new_sel != `PATU_TSEL_HI_ONLY);
				end
			end else if (timing && fr_hit) begin
				timer <= timer - 8'h01;
			end
		end
	end

	// Decoded lock window and current ratio
	always @(posedge clk_i) begin
		if (rst_i) begin
			lock_window_osc_o <= `PATU_LOCK_WIN_NARROW;
			current_ratio_o <= `PATU_RATIO_NARROW;
		end else begin
			lock_window_osc_o <= lock_window_select_o ? `PATU_LOCK_WIN_WIDE : `PATU_LOCK_WIN_NARROW;
			current_ratio_o <= current_ratio_select_o ? `PATU_RATIO_WIDE : `PATU_RATIO_NARROW;
		end
	end

	// Wishbone classic slave, one wait state
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes land at the edge where the master samples ack high
	assign wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

	always @* begin
		next_dat = 32'h00000000;
		case (wb_adr_i)
			`PATU_OFF_CTRL: begin
				next_dat[1:0] = ctrl;
			end
			`PATU_OFF_STATUS: begin
				next_dat[`PATU_ST_HI] = detector_high_current_out_o;
				next_dat[`PATU_ST_LO] = detector_low_current_out_o;
				next_dat[`PATU_ST_TIMING] = timing;
				next_dat[`PATU_ST_PENDING] = pend_valid;
				next_dat[`PATU_ST_MODE_ERR] = mode_err;
				next_dat[`PATU_ST_GAP_ERR] = gap_err;
			end
			`PATU_OFF_HOLD_REF: begin
				next_dat[15:0] = ref_divider_holding_reg;
			end
			`PATU_OFF_ACT_REF: begin
				next_dat[15:0] = active_ref_o;
			end
			`PATU_OFF_ACT_MAIN: begin
				next_dat[23:0] = {1'b0, lock_window_select_o, adapt_timer_select, current_ratio_select_o,
					active_main_o};
			end
			`PATU_OFF_TIMER: begin
				next_dat[7:0] = timer;
			end
			default: begin
				next_dat = 32'h00000000;
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			ctrl <= `PATU_CTRL_RESET;
			mode_err <= 1'b0;
			gap_err <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= (wb_req && !wb_we_i) ? next_dat : 32'h00000000;
			if (wb_wr && wb_adr_i == `PATU_OFF_CTRL) begin
				ctrl <= wb_dat_i[1:0];
			end
			// Hardware set wins over a software clear in the same cycle
			if (word_n && s_mode && !shreg[`PATU_N_MODE]) begin
				mode_err <= 1'b1;
			end else if (wb_wr && wb_adr_i == `PATU_OFF_STATUS && wb_dat_i[`PATU_ST_MODE_ERR]) begin
				mode_err <= 1'b0;
			end
			if (enb_fall && gap_cnt != `PATU_GAP_OSC_CYCLES) begin
				gap_err <= 1'b1;
			end else if (wb_wr && wb_adr_i == `PATU_OFF_STATUS && wb_dat_i[`PATU_ST_GAP_ERR]) begin
				gap_err <= 1'b0;
			end
		end
	end
endmodule // patu_top

// *** patu_top_asserts.sv ***
`timescale 1ns/1ps
module patu_top_chk (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire [31:0] wb_dat_o,
	input wire detector_high_current_out_o,
	input wire detector_low_current_out_o,
	input wire ref_divided_compare_rate_o,
	input wire lock_window_select_o,
	input wire [6:0] lock_window_osc_o,
	input wire current_ratio_select_o,
	input wire [3:0] current_ratio_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
	drive_excl_a: assert property (detector_high_current_out_o != detector_low_current_out_o)
		else $error("detector drive not exclusive");
	drive_handover_a: assert property ($rose(detector_low_current_out_o) |->
		$fell(detector_high_current_out_o)) else $error("handover broken");
	lock_win_a: assert property (!lock_window_select_o ##1 !lock_window_select_o |->
		lock_window_osc_o == 7'h20) else $error("lock window wrong");
	ratio_sel_a: assert property (!current_ratio_select_o ##1 !current_ratio_select_o |->
		current_ratio_o == 4'h4) else $error("current ratio wrong");
	rate_pulse_a: assert property (ref_divided_compare_rate_o |=> !ref_divided_compare_rate_o)
		else $error("compare pulse too long");
endmodule // patu_top_chk
bind patu_top patu_top_chk i_patu_top_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
	.detector_high_current_out_o(detector_high_current_out_o),
	.detector_low_current_out_o(detector_low_current_out_o),
	.ref_divided_compare_rate_o(ref_divided_compare_rate_o), .lock_window_select_o(lock_window_select_o),
	.lock_window_osc_o(lock_window_osc_o), .current_ratio_select_o(current_ratio_select_o),
	.current_ratio_o(current_ratio_o));

// *** patu_host.sv ***
`timescale 1ns/1ps
module patu_host (
	output logic ser_clk_o,
	output logic ser_data_o,
	output logic ser_enb_n_o
);
	initial begin
		ser_clk_o = 1'b0;
		ser_data_o = 1'b0;
		ser_enb_n_o = 1'b1;
	end
	// Word MSB first; link clock idles low outside frames
	task automatic send(input logic [23:0] w, input int n);
		ser_enb_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			ser_data_o = w[i];
			#62.5 ser_clk_o = 1'b1;
			#62.5 ser_clk_o = 1'b0;
		end
		#62.5 ser_enb_n_o = 1'b1;
		ser_data_o = ~ser_data_o;
		#500;
	endtask
endmodule // patu_host

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
	logic clk_i, rst_i, cyc, stb, we, mode, ack, hi, lo, lo_q, fr;
	logic [3:0] sel;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, rnd;
	logic [15:0] aref, npls, ncyc;
	logic [17:0] amain;
	logic [6:0] lwo;
	logic [3:0] cro;
	logic sclk, sdat, senb;
	logic [31:0] rq[$], evq[$];
	int fail_count, checks, cycles;
	patu_top i_patu_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ser_clk_i(sclk), .ser_data_i(sdat), .ser_enb_n_i(senb), .mode_i(mode),
		.detector_high_current_out_o(hi), .detector_low_current_out_o(lo),
		.ref_divided_compare_rate_o(fr), .active_ref_o(aref), .active_main_o(amain),
		.lock_window_select_o(), .lock_window_osc_o(lwo), .current_ratio_select_o(), .current_ratio_o(cro));
	patu_host i_patu_host (.ser_clk_o(sclk), .ser_data_o(sdat), .ser_enb_n_o(senb));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 100);
		if (n == 100)
			fail_count++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		rq.push_back(exp);
		wb(1'b0, a, 32'h0, 4'hF);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			results();
		end
		if (ack === 1'b1 && we === 1'b0 && rq.size() > 0)
			chk(rdat, rq.pop_front());
		lo_q <= lo;
		if (amain === 18'h00123 && lo === 1'b0) begin
			npls <= npls + {15'h0, fr};
			ncyc <= ncyc + 16'h1;
		end
		if (lo === 1'b1 && lo_q === 1'b0 && evq.size() > 0) begin
			// The last pulse of the interval arrives with the switch itself
			chk({16'h0, npls + {15'h0, fr}}, evq.pop_front());
			chk({31'h0, ncyc >= 16'd1250 && ncyc <= 16'd1300}, 32'h1);
		end
	end
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, sel, adr, wdat} = '0;
		{npls, ncyc, lo_q} = '0;
		mode = 1'b1;
		rnd = $urandom(32'hF8EFB8EF);
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h00, 32'h3);
		wb(1'b1, 8'h00, 32'h0, 4'hE);
		rd(8'h00, 32'h3);
		rd(8'hFC, 32'h0);
		evq.push_back(32'h20);
		i_patu_host.send(24'h000051, 16);
		i_patu_host.send(24'hA80123, 24);
		rd(8'h10, 32'h00280123);
		rd(8'h04, 32'h05);
		i_patu_host.send(24'h000014, 16);
		i_patu_host.send(24'h880456, 24);
		rd(8'h10, 32'h00280123);
		rd(8'h04, 32'h0D);
		for (int k = 0; k < 2000 && lo !== 1'b1; k++) @(posedge clk_i);
		rd(8'h10, 32'h00080456);
		rd(8'h0C, 32'h14);
		rd(8'h04, 32'h02);
		rnd = $urandom & 32'h0047FFFF;
		i_patu_host.send(rnd[23:0], 24);
		rd(8'h10, rnd);
		rd(8'h04, 32'h11);
		chk({25'h0, lwo}, rnd[22] ? 32'h40 : 32'h20);
		chk({28'h0, cro}, rnd[18] ? 32'h8 : 32'h4);
		wb(1'b1, 8'h04, 32'h10, 4'h1);
		rd(8'h04, 32'h01);
		wb(1'b1, 8'h00, 32'h1, 4'h1);
		rd(8'h00, 32'h1);
		mode <= 1'b0;
		i_patu_host.send(24'h280789, 24);
		rd(8'h10, 32'h00280789);
		rd(8'h04, 32'h02);
		chk({16'h0, aref}, 32'h14);
		results();
	end
endmodule // tb
